// ===== core/mscr_top.sv
// Miscellaneous system control register with its AHB-Lite slave and controlled functions.
// What this block does
// - Power-on reset sets the power-on flag
// - Flag ignores written ones, clears on zero
// - Select bits set external pin sensitivity
// - Same bits set wired-OR sensitivity, opposite polarity
// - Select writes need interrupt mask; reset clears
// - Enable bit gates external pin interrupt
// - Enable writes need mask; reset sets it
// - Modulator A period 4096 or 256 clocks
// - Modulator B period 4096 or 256 clocks
// - Rate is overflow rate times 256 or 16
// - Slow mode divides bus rate by sixteen
// - Slow mode clears on reset and stop
// - Writing one clears and enables watchdog
// - Writing zero to watchdog bit does nothing
// - After reset watchdog bit follows mask option
`timescale 1ns/1ps
`default_nettype none
module mscr_top #(
	parameter int DEC_W = 12
) (
	input  wire logic                               CLK,
	input  wire logic                               RSTN,
	input  wire logic                               CE,
	input  wire logic                               HSEL,
	input  wire logic [31:0]                        HADDR,
	input  wire logic [1:0]                         HTRANS,
	input  wire logic                               HWRITE,
	input  wire logic [2:0]                         HSIZE,
	input  wire logic [31:0]                        HWDATA,
	input  wire logic                               HREADY,
	output logic      [31:0]                        HRDATA,
	output logic                                    HREADYOUT,
	output logic                                    HRESP,
	input  wire logic                               CPU_IMASK,
	input  wire logic                               STOP_ENTRY,
	input  wire logic                               RESET_CAUSE_POR,
	input  wire logic                               WATCHDOG_ENABLE_BIT_MASK_OPT,
	input  wire logic                               EXT_IRQ_PIN,
	input  wire logic                               WOR_LEVEL,
	output logic                                    EXT_IRQ_REQ,
	output logic                                    WOR_REQ,
	output logic      [mscr_pkg::MSCR_PERIOD_W-1:0] PWM_A_PERIOD,
	output logic      [mscr_pkg::MSCR_PERIOD_W-1:0] PWM_B_PERIOD,
	output logic                                    BUS_SLOW_MODE,
	output logic                                    BUS_TICK,
	output logic                                    WATCHDOG_ENABLE_BIT_ENABLE,
	output logic                                    WATCHDOG_ENABLE_BIT_CLEAR
);
	import mscr_pkg::*;

	if (DEC_W < MSCR_ADDR_W || DEC_W > 32) begin : g_chk
		$error("mscr_top decode width out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Declarations.
	mscr_bus_type              state_r;
	mscr_bus_type              state_nxt;
	logic [DEC_W-1:0]          addr_r;
	logic [31:0]               hrdata_r;
	logic                      ready_r;
	logic                      init_done_r;
	logic                      por_r;
	logic                      rise_sel_r;
	logic                      fall_sel_r;
	logic                      int_en_r;
	logic                      pwm_a_slow_r;
	logic                      pwm_b_slow_r;
	logic                      slow_mode_r;
	logic                      watchdog_enable_bit_en_r;
	logic                      watchdog_enable_bit_clr_r;
	logic [MSCR_PERIOD_W-1:0]  pwm_a_period_r;
	logic [MSCR_PERIOD_W-1:0]  pwm_b_period_r;
	logic [MSCR_DIV_W-1:0]     div_r;
	logic [MSCR_DIV_W-1:0]     div_nxt;
	logic                      tick_r;
	logic                      addr_accept;
	logic                      reg_hit;
	logic                      reg_wr;
	logic                      mask_wr;
	logic [MSCR_BYTE_W-1:0]    wbyte;
	logic [MSCR_BYTE_W-1:0]    misc_byte;
	logic                      por_nxt;
	logic                      slow_nxt;
	logic                      watchdog_enable_bit_nxt;
	logic                      watchdog_enable_bit_kick;
	logic [1:0]                pin_s;

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite decode. Upper address bits beyond the decode width alias.
	assign addr_accept = HSEL & HTRANS[1] & HREADY;
	assign reg_hit     = (addr_r == DEC_W'(MSCR_MISC_ADDR));
	assign reg_wr      = CE & (state_r == MSCR_BUS_WRITE) & reg_hit;
	assign mask_wr     = reg_wr & CPU_IMASK;
	assign wbyte       = HWDATA[MSCR_BYTE_W-1:0];
	assign misc_byte   = {por_r, rise_sel_r, fall_sel_r, int_en_r,
	                      pwm_a_slow_r, pwm_b_slow_r, slow_mode_r, watchdog_enable_bit_en_r};

	// Reads take one wait state so that a write just before is always seen.
	always_comb begin
		case (state_r)
			MSCR_BUS_READ: begin
				state_nxt = MSCR_BUS_RDONE;
			end
			default: begin
				if (addr_accept) begin
					state_nxt = HWRITE ? MSCR_BUS_WRITE : MSCR_BUS_READ;
				end else begin
					state_nxt = MSCR_BUS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			state_r <= MSCR_BUS_IDLE;
			ready_r <= 1'b1;
		end else if (CE) begin
			state_r <= state_nxt;
			ready_r <= (state_nxt != MSCR_BUS_READ);
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			addr_r <= '0;
		end else if (CE && addr_accept) begin
			addr_r <= HADDR[DEC_W-1:0];
		end
	end

	// Unmapped addresses read as zero and ignore writes; the answer is always OKAY.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			hrdata_r <= MSCR_WORD_ZERO;
		end else if (CE && state_r == MSCR_BUS_READ) begin
			hrdata_r <= reg_hit ? {MSCR_PAD_ZERO, misc_byte} : MSCR_WORD_ZERO;
		end
	end

	assign HRDATA    = hrdata_r;
	assign HREADYOUT = ready_r;
	assign HRESP     = 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// Reset-time capture. Cause and mask option come from the reset controller on this clock.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			init_done_r <= 1'b0;
		end else if (CE) begin
			init_done_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register fields.
	assign por_nxt = !init_done_r ? RESET_CAUSE_POR :
	                 (reg_wr && !wbyte[MSCR_BIT_POR]) ? 1'b0 : por_r;

	assign slow_nxt = STOP_ENTRY ? 1'b0 :
	                  reg_wr ? wbyte[MSCR_BIT_SLOW] : slow_mode_r;

	// A written zero is dropped, so software can never stop a running watchdog.
	assign watchdog_enable_bit_kick = reg_wr & wbyte[MSCR_BIT_WATCHDOG_ENABLE_BIT];
	assign watchdog_enable_bit_nxt  = !init_done_r ? WATCHDOG_ENABLE_BIT_MASK_OPT :
	                   watchdog_enable_bit_kick ? 1'b1 : watchdog_enable_bit_en_r;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			por_r       <= MSCR_POR_RST;
			slow_mode_r <= MSCR_SLOW_RST;
			watchdog_enable_bit_en_r   <= MSCR_WATCHDOG_ENABLE_BIT_RST;
			watchdog_enable_bit_clr_r  <= 1'b0;
		end else if (CE) begin
			por_r       <= por_nxt;
			slow_mode_r <= slow_nxt;
			watchdog_enable_bit_en_r   <= watchdog_enable_bit_nxt;
			watchdog_enable_bit_clr_r  <= watchdog_enable_bit_kick;
		end
	end

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rise_sel_r <= MSCR_SEL_RST;
			fall_sel_r <= MSCR_SEL_RST;
			int_en_r   <= MSCR_INTEN_RST;
		end else if (mask_wr) begin
			rise_sel_r <= wbyte[MSCR_BIT_RISE];
			fall_sel_r <= wbyte[MSCR_BIT_FALL];
			int_en_r   <= wbyte[MSCR_BIT_INTEN];
		end
	end

	// Selects are single buffered; software must set them before the modulator values.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pwm_a_slow_r <= MSCR_PWM_RST;
			pwm_b_slow_r <= MSCR_PWM_RST;
		end else if (reg_wr) begin
			pwm_a_slow_r <= wbyte[MSCR_BIT_PWMA];
			pwm_b_slow_r <= wbyte[MSCR_BIT_PWMB];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Modulator periods. The two figures follow from the overflow interval over 256 and 16.
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			pwm_a_period_r <= MSCR_PERIOD_FAST;
			pwm_b_period_r <= MSCR_PERIOD_FAST;
		end else if (CE) begin
			pwm_a_period_r <= pwm_a_slow_r ? MSCR_PERIOD_SLOW : MSCR_PERIOD_FAST;
			pwm_b_period_r <= pwm_b_slow_r ? MSCR_PERIOD_SLOW : MSCR_PERIOD_FAST;
		end
	end

	assign PWM_A_PERIOD = pwm_a_period_r;
	assign PWM_B_PERIOD = pwm_b_period_r;

	////////////////////////////////////////////////////////////////////////////////
	// Bus rate divider. A mode change takes effect at the next tick, so no tick is ever short.
	assign div_nxt = (div_r != MSCR_DIV_ZERO) ? div_r - 5'h01 :
	                 slow_mode_r ? MSCR_DIV_SLOW_M1 : MSCR_DIV_NORM_M1;

	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			div_r  <= MSCR_DIV_ZERO;
			tick_r <= 1'b0;
		end else if (CE) begin
			div_r  <= div_nxt;
			tick_r <= (div_r == MSCR_DIV_ZERO);
		end
	end

	assign BUS_TICK      = tick_r;
	assign BUS_SLOW_MODE = slow_mode_r;
	assign WATCHDOG_ENABLE_BIT_ENABLE   = watchdog_enable_bit_en_r;
	assign WATCHDOG_ENABLE_BIT_CLEAR    = watchdog_enable_bit_clr_r;

	////////////////////////////////////////////////////////////////////////////////
	// Interrupt sources. The active-low pin enters the synchroniser inverted, so cleared flops read as an idle pin.
	mscr_sync #(
		.W (2)
	) u_sync (
		.clk  (CLK),
		.rstn (RSTN),
		.ce   (CE),
		.d    ({~EXT_IRQ_PIN, WOR_LEVEL}),
		.q    (pin_s)
	);

	mscr_sense #(
		.ACTIVE_LOW (1'b0)
	) u_ext_sense (
		.clk  (CLK),
		.rstn (RSTN),
		.ce   (CE),
		.lvl  (pin_s[1]),
		.en   (int_en_r),
		.code ({rise_sel_r, fall_sel_r}),
		.req  (EXT_IRQ_REQ)
	);

	mscr_sense #(
		.ACTIVE_LOW (1'b0)
	) u_wor_sense (
		.clk  (CLK),
		.rstn (RSTN),
		.ce   (CE),
		.lvl  (pin_s[0]),
		.en   (1'b1),
		.code ({rise_sel_r, fall_sel_r}),
		.req  (WOR_REQ)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_por_set;
		@(posedge CLK) disable iff (!RSTN)
		(CE && !init_done_r && RESET_CAUSE_POR) |=> por_r;
	endproperty
	a_por_set: assert property (p_por_set) else $error("power-on flag not set");

	property p_por_write;
		@(posedge CLK) disable iff (!RSTN)
		(reg_wr && init_done_r) |=> (por_r == ($past(por_r) & $past(wbyte[MSCR_BIT_POR])));
	endproperty
	a_por_write: assert property (p_por_write) else $error("power-on flag write wrong");

	property p_sel_locked;
		@(posedge CLK) disable iff (!RSTN)
		(reg_wr && !CPU_IMASK) |=> $stable({rise_sel_r, fall_sel_r, int_en_r});
	endproperty
	a_sel_locked: assert property (p_sel_locked) else $error("select written while unmasked");

	property p_inten_write;
		@(posedge CLK) disable iff (!RSTN)
		mask_wr |=> (int_en_r == $past(wbyte[MSCR_BIT_INTEN]));
	endproperty
	a_inten_write: assert property (p_inten_write) else $error("enable bit not written");

	property p_ext_gate;
		@(posedge CLK) disable iff (!RSTN)
		(CE && !int_en_r) |=> !EXT_IRQ_REQ;
	endproperty
	a_ext_gate: assert property (p_ext_gate) else $error("request while disabled");

	property p_period_a;
		@(posedge CLK) disable iff (!RSTN)
		(CE && pwm_a_slow_r) ##1 (CE && pwm_a_slow_r) |=> (PWM_A_PERIOD == MSCR_PERIOD_SLOW);
	endproperty
	a_period_a: assert property (p_period_a) else $error("modulator A period wrong");

	property p_period_b;
		@(posedge CLK) disable iff (!RSTN)
		(CE && !pwm_b_slow_r) |=> (PWM_B_PERIOD == MSCR_PERIOD_FAST);
	endproperty
	a_period_b: assert property (p_period_b) else $error("modulator B period wrong");

	property p_div_reload;
		@(posedge CLK) disable iff (!RSTN)
		(CE && div_r == MSCR_DIV_ZERO) |=>
			(div_r == ($past(slow_mode_r) ? MSCR_DIV_SLOW_M1 : MSCR_DIV_NORM_M1)) && BUS_TICK;
	endproperty
	a_div_reload: assert property (p_div_reload) else $error("bus divider reload wrong");

	property p_stop_clear;
		@(posedge CLK) disable iff (!RSTN)
		(CE && STOP_ENTRY) |=> !BUS_SLOW_MODE;
	endproperty
	a_stop_clear: assert property (p_stop_clear) else $error("slow mode kept in stop");

	property p_watchdog_enable_bit_kick;
		@(posedge CLK) disable iff (!RSTN)
		watchdog_enable_bit_kick |=> (WATCHDOG_ENABLE_BIT_CLEAR && WATCHDOG_ENABLE_BIT_ENABLE);
	endproperty
	a_watchdog_enable_bit_kick: assert property (p_watchdog_enable_bit_kick) else $error("watchdog kick lost");

	property p_watchdog_enable_bit_hold;
		@(posedge CLK) disable iff (!RSTN)
		(CE && init_done_r && watchdog_enable_bit_en_r) |=> watchdog_enable_bit_en_r;
	endproperty
	a_watchdog_enable_bit_hold: assert property (p_watchdog_enable_bit_hold) else $error("watchdog disabled by software");

	property p_watchdog_enable_bit_init;
		@(posedge CLK) disable iff (!RSTN)
		(CE && !init_done_r) |=> (watchdog_enable_bit_en_r == $past(WATCHDOG_ENABLE_BIT_MASK_OPT));
	endproperty
	a_watchdog_enable_bit_init: assert property (p_watchdog_enable_bit_init) else $error("watchdog reset value wrong");
endmodule
`default_nettype wire

// ===== pkg/mscr_pkg.sv
// Constants, field layout and types of the miscellaneous system control register block.
package mscr_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register map and field positions.
	localparam int unsigned MSCR_ADDR_W    = 12;
	localparam logic [11:0] MSCR_MISC_ADDR = 12'h00C;
	localparam int unsigned MSCR_BYTE_W    = 8;
	localparam int unsigned MSCR_BIT_POR   = 7;
	localparam int unsigned MSCR_BIT_RISE  = 6;
	localparam int unsigned MSCR_BIT_FALL  = 5;
	localparam int unsigned MSCR_BIT_INTEN = 4;
	localparam int unsigned MSCR_BIT_PWMA  = 3;
	localparam int unsigned MSCR_BIT_PWMB  = 2;
	localparam int unsigned MSCR_BIT_SLOW  = 1;
	localparam int unsigned MSCR_BIT_WATCHDOG_ENABLE_BIT  = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values of the plain fields.
	localparam logic MSCR_POR_RST   = 1'h0;
	localparam logic MSCR_SEL_RST   = 1'h0;
	localparam logic MSCR_INTEN_RST = 1'h1;
	localparam logic MSCR_PWM_RST   = 1'h0;
	localparam logic MSCR_SLOW_RST  = 1'h0;
	localparam logic MSCR_WATCHDOG_ENABLE_BIT_RST  = 1'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Modulator periods in timer clocks, derived from the timer overflow interval.
	localparam int unsigned MSCR_TIMER_WRAP   = 65536;
	localparam int unsigned MSCR_RATE_FAST    = 256;
	localparam int unsigned MSCR_RATE_SLOW    = 16;
	localparam int unsigned MSCR_PERIOD_W     = 13;
	localparam logic [12:0] MSCR_PERIOD_FAST  = 13'(MSCR_TIMER_WRAP / MSCR_RATE_FAST);
	localparam logic [12:0] MSCR_PERIOD_SLOW  = 13'(MSCR_TIMER_WRAP / MSCR_RATE_SLOW);

	////////////////////////////////////////////////////////////////////////////////
	// Bus rate divider: normal rate is the oscillator over two, slow mode sixteen times lower.
	localparam int unsigned MSCR_DIV_W       = 5;
	localparam int unsigned MSCR_DIV_NORMAL  = 2;
	localparam int unsigned MSCR_SLOW_FACTOR = 16;
	localparam logic [4:0]  MSCR_DIV_NORM_M1 = 5'(MSCR_DIV_NORMAL - 1);
	localparam logic [4:0]  MSCR_DIV_SLOW_M1 = 5'(MSCR_DIV_NORMAL * MSCR_SLOW_FACTOR - 1);
	localparam logic [4:0]  MSCR_DIV_ZERO    = 5'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave states, Gray coded along idle, read, read done.
	typedef enum logic [1:0] {
		MSCR_BUS_IDLE  = 2'h0,
		MSCR_BUS_READ  = 2'h1,
		MSCR_BUS_RDONE = 2'h3,
		MSCR_BUS_WRITE = 2'h2
	} mscr_bus_type;

	localparam logic [31:0] MSCR_WORD_ZERO = 32'h0000_0000;
	localparam logic [23:0] MSCR_PAD_ZERO  = 24'h00_0000;

endpackage

// ===== core/mscr_sync.sv
// Two flip-flop synchroniser for asynchronous pin levels.
`timescale 1ns/1ps
`default_nettype none
module mscr_sync #(
	parameter int W = 2
) (
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_r;

	if (W < 1) begin : g_chk
		$error("mscr_sync width must be at least one");
	end

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			meta_r <= '0;
			q      <= '0;
		end else if (ce) begin
			meta_r <= d;
			q      <= meta_r;
		end
	end
endmodule
`default_nettype wire

// ===== core/mscr_sense.sv
// Edge and level sensitivity detector for one interrupt source.
`timescale 1ns/1ps
`default_nettype none
module mscr_sense #(
	parameter bit ACTIVE_LOW = 1'b1
) (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	input  wire logic       lvl,
	input  wire logic       en,
	input  wire logic [1:0] code,
	output logic            req
);
	logic prev_r;
	logic asserted;
	logic rise_edge;
	logic fall_edge;
	logic hit;

	// Code 00 is asserting edge plus level, 01 asserting edge, 10 releasing edge, 11 both edges.
	assign asserted  = lvl ^ ACTIVE_LOW;
	assign rise_edge = asserted & ~prev_r;
	assign fall_edge = ~asserted & prev_r;
	assign hit       = (code == 2'h0) ? asserted :
	                   (code == 2'h1) ? rise_edge :
	                   (code == 2'h2) ? fall_edge :
	                   (rise_edge | fall_edge);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			prev_r <= 1'b0;
			req    <= 1'b0;
		end else if (ce) begin
			prev_r <= asserted;
			req    <= en & hit;
		end
	end

	property p_level_mode;
		@(posedge clk) disable iff (!rstn)
		(ce && en && code == 2'h0 && asserted) |=> req;
	endproperty
	a_level_mode: assert property (p_level_mode) else $error("level mode request missing");
endmodule
`default_nettype wire

// ===== tb/mscr_top_tb.sv
// Self-checking testbench for the miscellaneous system control register block.
`timescale 1ns/1ps
`default_nettype none
module mscr_top_tb;
	import mscr_pkg::*;

	logic        clk, rstn, ce, hsel, hwrite, imask, stop_entry, por_cause, watchdog_enable_bit_opt, ext_pin, wor_level;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire  logic [31:0] hrdata;
	wire  logic [12:0] pwm_a_period, pwm_b_period;
	wire  logic  hreadyout, hresp, ext_irq_req, wor_req, bus_slow_mode, bus_tick, watchdog_enable_bit_enable, watchdog_enable_bit_clear;
	integer      n_mismatch = 0;
	integer      cmp_count  = 0;
	integer      seed       = 65990;
	integer      cycles     = 0;
	int          ext_pulses = 0;
	int          wor_pulses = 0;
	int          clr_pulses = 0;
	logic        ext_q, wor_q, clr_q, rd_phase;
	logic [7:0]  mdl;
	logic [31:0] exp_q[$];
	logic [2:0]  irq_tab[6] = '{3'b011, 3'b101, 3'b111, 3'b001, 3'b000, 3'b010};

	mscr_top #(.DEC_W(12)) dut (
		.CLK(clk), .RSTN(rstn), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
		.HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .CPU_IMASK(imask), .STOP_ENTRY(stop_entry), .RESET_CAUSE_POR(por_cause),
		.WATCHDOG_ENABLE_BIT_MASK_OPT(watchdog_enable_bit_opt), .EXT_IRQ_PIN(ext_pin), .WOR_LEVEL(wor_level), .EXT_IRQ_REQ(ext_irq_req),
		.WOR_REQ(wor_req), .PWM_A_PERIOD(pwm_a_period), .PWM_B_PERIOD(pwm_b_period),
		.BUS_SLOW_MODE(bus_slow_mode), .BUS_TICK(bus_tick), .WATCHDOG_ENABLE_BIT_ENABLE(watchdog_enable_bit_enable), .WATCHDOG_ENABLE_BIT_CLEAR(watchdog_enable_bit_clear)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Clock, checking, verdict and hang guard.
	initial begin
		clk = 1'b0; rstn = 1'b0; ce = 1'b1; hsel = 1'b0; hwrite = 1'b0; imask = 1'b0; stop_entry = 1'b0;
		por_cause = 1'b1; watchdog_enable_bit_opt = 1'b0; ext_pin = 1'b1; wor_level = 1'b0; haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000; htrans = 2'h0; hsize = 3'h2; rd_phase = 1'b0; mdl = 8'h00;
	end

	always #2.5 clk = ~clk;

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task close_out;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// A run of about six hundred cycles is expected; the ceiling leaves wide margin for slow-mode waits.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			close_out();
		end
	end

	// Read data is judged at the edge that ends the read data phase, oldest expectation first.
	always @(posedge clk) begin
		if (rd_phase && hreadyout === 1'b1) begin
			chk("hresp", 32'(hresp), 32'h0000_0000);
			chk("hrdata", hrdata, exp_q.pop_front());
		end
	end

	always @(posedge clk) begin
		ext_q <= ext_irq_req;
		wor_q <= wor_req;
		clr_q <= watchdog_enable_bit_clear;
		if (ext_irq_req === 1'b1 && ext_q === 1'b0) ext_pulses++;
		if (wor_req === 1'b1 && wor_q === 1'b0) wor_pulses++;
		if (watchdog_enable_bit_clear === 1'b1 && clr_q === 1'b0) clr_pulses++;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus master tasks; all are entered just after a rising edge.
	task wait_rdy;
		logic r;
		do begin
			@(negedge clk);
			r = hreadyout;
			@(posedge clk);
		end while (r !== 1'b1);
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		int c0;
		c0 = clr_pulses;
		hsel <= 1'b1; haddr <= {20'h0_0000, a}; htrans <= 2'h2; hwrite <= 1'b1;
		wait_rdy();
		htrans <= 2'h0; hwdata <= {24'h00_0000, d};
		wait_rdy();
		hsel <= 1'b0;
		if (a == MSCR_MISC_ADDR) begin
			mdl[7] = mdl[7] & d[7];
			if (imask) mdl[6:4] = d[6:4];
			mdl[3:1] = d[3:1];
			mdl[0] = mdl[0] | d[0];
		end
		repeat (3) @(posedge clk);
		chk("watchdog_enable_bit_clear", 32'(clr_pulses - c0), 32'(d[0] && a == MSCR_MISC_ADDR));
	endtask

	task rd(input logic [11:0] a, input logic [7:0] exp);
		exp_q.push_back({24'h00_0000, exp});
		hsel <= 1'b1; haddr <= {20'h0_0000, a}; htrans <= 2'h2; hwrite <= 1'b0;
		wait_rdy();
		htrans <= 2'h0; rd_phase <= 1'b1;
		wait_rdy();
		rd_phase <= 1'b0; hsel <= 1'b0;
		@(negedge clk);
		chk("pwm_a_period", 32'(pwm_a_period), mdl[3] ? 32'h0000_1000 : 32'h0000_0100);
		chk("pwm_b_period", 32'(pwm_b_period), mdl[2] ? 32'h0000_1000 : 32'h0000_0100);
		chk("bus_slow_mode", 32'(bus_slow_mode), 32'(mdl[1]));
		chk("watchdog_enable_bit_enable", 32'(watchdog_enable_bit_enable), 32'(mdl[0]));
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenario tasks.
	task do_reset(input logic por, input logic wopt);
		rstn <= 1'b0; por_cause <= por; watchdog_enable_bit_opt <= wopt;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		mdl = {por, 3'b001, 3'b000, wopt};
		rd(MSCR_MISC_ADDR, mdl);
	endtask

	task rand_regs(input int n);
		logic [7:0] d;
		for (int i = 0; i < n; i++) begin
			d = 8'($random(seed));
			imask <= 1'($random(seed));
			wr(MSCR_MISC_ADDR, d);
			rd(MSCR_MISC_ADDR, mdl);
		end
	endtask

	// The divider picks up a new mode at its next reload, so one gap is skipped before measuring.
	task tick_gap(input int exp);
		int g;
		@(negedge clk);
		while (bus_tick !== 1'b1) @(negedge clk);
		@(negedge clk);
		while (bus_tick !== 1'b1) @(negedge clk);
		g = 0;
		do begin
			@(negedge clk);
			g++;
		end while (bus_tick !== 1'b1);
		chk("bus_tick_gap", 32'(g), 32'(exp));
		@(posedge clk);
	endtask

	// An odd number of frozen cycles, so a divider that kept running would show the other tick level.
	task ce_freeze;
		logic t;
		ce <= 1'b0;
		@(negedge clk);
		t = bus_tick;
		repeat (7) @(negedge clk);
		chk("ce_freeze_tick", 32'(bus_tick), 32'(t));
		@(posedge clk);
		ce <= 1'b1;
		@(posedge clk);
	endtask

	// Table entry holds the sensitivity code in its upper two bits and the enable in bit 0.
	task irq_case(input logic [2:0] v);
		int ep, wp, np;
		imask <= 1'b1;
		wr(MSCR_MISC_ADDR, {1'b0, v, 4'h0});
		repeat (6) @(posedge clk);
		ep = ext_pulses;
		wp = wor_pulses;
		ext_pin <= 1'b0; wor_level <= 1'b1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk("ext_req_hold", 32'(ext_irq_req), 32'(v == 3'b001));
		chk("wor_req_hold", 32'(wor_req), 32'(v[2:1] == 2'b00));
		@(posedge clk);
		ext_pin <= 1'b1; wor_level <= 1'b0;
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk("ext_req_idle", 32'(ext_irq_req), 32'h0000_0000);
		chk("wor_req_idle", 32'(wor_req), 32'h0000_0000);
		np = (v[2:1] == 2'b11) ? 2 : 1;
		if (v[2:1] != 2'b00) begin
			chk("ext_pulses", 32'(ext_pulses - ep), v[0] ? 32'(np) : 32'h0000_0000);
			chk("wor_pulses", 32'(wor_pulses - wp), 32'(np));
		end
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		@(posedge clk);
		do_reset(1'b1, 1'b0);
		rand_regs(16);
		imask <= 1'b1;
		wr(12'h010, 8'hFF);
		rd(12'h010, 8'h00);
		rd(MSCR_MISC_ADDR, mdl);
		wr(MSCR_MISC_ADDR, 8'h1E);
		rd(MSCR_MISC_ADDR, mdl);
		tick_gap(32);
		stop_entry <= 1'b1;
		@(posedge clk);
		stop_entry <= 1'b0;
		mdl[1] = 1'b0;
		rd(MSCR_MISC_ADDR, mdl);
		tick_gap(2);
		ce_freeze();
		foreach (irq_tab[i]) irq_case(irq_tab[i]);
		do_reset(1'b0, 1'b1);
		imask <= 1'b1;
		wr(MSCR_MISC_ADDR, 8'h80);
		rd(MSCR_MISC_ADDR, mdl);
		rand_regs(8);
		close_out();
	end
endmodule
`default_nettype wire
